// ==== core/cmm_pkg.sv ====
/*
 * cmm_pkg: memory map, status word layout and sequencing constants for the
 * core control-register block. Assumes a 64 KB byte address space.
 */
package cmm_pkg;
    localparam logic [15:0] VEC_BASE = 16'h0000;
    localparam logic [15:0] VEC_LAST = 16'h003F;
    localparam logic [15:0] VEC_IRQ_FIRST = 16'h0004;
    localparam logic [15:0] VEC_IRQ_LAST = 16'h002E;
    localparam logic [15:0] VEC_TIMER_H1 = 16'h001A;
    localparam logic [15:0] VEC_BREAK = 16'h003E;
    localparam logic [15:0] TCALL_BASE = 16'h0040;
    localparam logic [15:0] TCALL_LAST = 16'h007F;
    localparam logic [15:0] SCALL_BASE = 16'h0800;
    localparam logic [15:0] SCALL_LAST = 16'h0FFF;
    localparam logic [15:0] ROM_END_16K = 16'h3FFF;
    localparam logic [15:0] ROM_END_24K = 16'h5FFF;
    localparam logic [15:0] ROM_END_32K = 16'h7FFF;
    localparam logic [15:0] RAM_BASE_512 = 16'hFD00;
    localparam logic [15:0] RAM_BASE_1K = 16'hFB00;
    localparam logic [15:0] RAM_END = 16'hFEFF;
    localparam logic [15:0] GPR_BASE = 16'hFEE0;
    localparam logic [15:0] SFR_BASE = 16'hFF00;
    localparam logic [7:0] PSW_RESET = 8'h02;
    localparam int PSW_IE = 7;
    localparam int PSW_Z = 6;
    localparam int PSW_BANK_SELECT_HIGH = 5;
    localparam int PSW_AC = 4;
    localparam int PSW_BANK_SELECT_LOW = 3;
    localparam int PSW_ISP = 1;
    localparam int PSW_CY = 0;
    localparam logic [7:0] PSW_WMASK = 8'hFB;
    // axi register byte addresses
    localparam logic [7:0] REG_PC = 8'h00;
    localparam logic [7:0] REG_PSW = 8'h04;
    localparam logic [7:0] REG_SP = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_VAR = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // cpu operations on the control registers
    typedef enum logic [3:0] {
        CMM_OP_NONE = 4'h0, CMM_OP_ADV = 4'h1, CMM_OP_BRANCH = 4'h2,
        CMM_OP_TCALL = 4'h3, CMM_OP_SCALL = 4'h4, CMM_OP_IRQ = 4'h5,
        CMM_OP_BRK = 4'h6, CMM_OP_PUSHPSW = 4'h7, CMM_OP_POPPSW = 4'h8,
        CMM_OP_RETURN_FROM_INTERRUPT = 4'h9, CMM_OP_EI = 4'hA, CMM_OP_DI = 4'hB,
        CMM_OP_SELRB = 4'hC, CMM_OP_ALU = 4'hD, CMM_OP_PUSH = 4'hE,
        CMM_OP_POP = 4'hF
    } cmm_op_type;
    typedef enum logic [2:0] {
        CMM_ST_RUN = 3'b000, CMM_ST_VLO = 3'b001, CMM_ST_VHI = 3'b011,
        CMM_ST_PUSH = 3'b010, CMM_ST_POP = 3'b110
    } cmm_state_type;
endpackage

// ==== core/cmm_ctrl.sv ====
/*
 * cmm_ctrl: program counter, status word, stack pointer and address map of
 * the 8-bit core. Assumes a byte-wide memory port that answers a read in
 * the same cycle as mem_req and an outside decoder for the interrupt sources.
 */
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module cmm_ctrl
    import cmm_pkg::*;
#(
    parameter logic [1:0] ROM_SIZE = 2'd2,
    parameter logic RAM_LARGE = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic op_valid,
    input wire cmm_op_type op_code,
    input wire logic [2:0] op_len,
    input wire logic [15:0] op_target,
    input wire logic [4:0] op_index,
    input wire logic [1:0] op_bank,
    input wire logic [7:0] alu_result,
    input wire logic alu_half_carry,
    input wire logic alu_carry,
    input wire logic irq_pending,
    input wire logic irq_low_priority,
    input wire logic [4:0] irq_index,
    output logic irq_accept,
    output logic busy,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic fetch_fault,
    output logic stack_fault,
    output logic sfr_select,
    output logic gpr_select,
    output logic [15:0] program_counter,
    output logic [7:0] program_status_word,
    output logic [15:0] stack_pointer
);
    cmm_state_type state_q, state_d;
    logic [15:0] pc_q, sp_q, vaddr_q;
    logic [7:0] psw_q, vlo_q;
    // word as it stood when the sequence began, so a return restores the enable flag
    logic [7:0] psw_save_q;
    logic sw_hold_q, held_ok_q;
    logic aw_done_q, w_done_q;
    logic [7:0] awaddr_q, araddr_q;
    logic [31:0] wdata_q;
    logic bvalid_q, bok_q, rvalid_q, rok_q;
    logic [31:0] rdata_q;

    // address map decodes
    logic [15:0] rom_end, ram_base;
    assign rom_end = (ROM_SIZE == 2'd0) ? ROM_END_16K :
                     (ROM_SIZE == 2'd1) ? ROM_END_24K : ROM_END_32K;
    assign ram_base = RAM_LARGE ? RAM_BASE_1K : RAM_BASE_512;
    logic in_rom, in_gpr, in_sfr, sp_in_ram, pc_in_ram;
    assign in_rom = pc_q <= rom_end;
    assign in_gpr = mem_addr >= GPR_BASE && mem_addr <= RAM_END;
    assign pc_in_ram = pc_q >= ram_base && pc_q <= RAM_END;
    assign in_sfr = mem_addr >= SFR_BASE;
    assign sp_in_ram = sp_q >= ram_base && sp_q <= RAM_END;

    logic [15:0] irq_vec, tcall_addr;
    assign irq_vec = VEC_IRQ_FIRST + {10'h000, irq_index, 1'b0};
    logic irq_vec_ok;
    assign irq_vec_ok = irq_vec <= VEC_IRQ_LAST;
    assign tcall_addr = TCALL_BASE + {10'h000, op_index, 1'b0};
    logic scall_ok;
    assign scall_ok = op_target >= SCALL_BASE && op_target <= SCALL_LAST;

    logic irq_ok;
    assign irq_ok = irq_pending && psw_q[PSW_IE] && irq_vec_ok &&
                    (psw_q[PSW_ISP] || !irq_low_priority);
    logic run, take_irq;
    assign run = state_q == CMM_ST_RUN && !sw_hold_q;
    assign take_irq = run && irq_ok && (!op_valid || op_code == CMM_OP_NONE);
    assign irq_accept = take_irq;
    assign busy = !run;
    cmm_op_type op;
    assign op = op_valid ? op_code : CMM_OP_NONE;

    always_comb begin
        state_d = state_q;
        mem_req = 1'b0;
        mem_we = 1'b0;
        mem_addr = pc_q;
        mem_wdata = psw_q;
        unique case (state_q)
            CMM_ST_RUN: begin
                if (take_irq || (run && (op == CMM_OP_TCALL || op == CMM_OP_BRK))) begin
                    state_d = CMM_ST_VLO;
                end else if (run && op == CMM_OP_PUSHPSW) begin
                    state_d = CMM_ST_PUSH;
                end else if (run && (op == CMM_OP_POPPSW || op == CMM_OP_RETURN_FROM_INTERRUPT)) begin
                    state_d = CMM_ST_POP;
                end
            end
            // low byte even, high byte odd
            CMM_ST_VLO: begin
                mem_req = 1'b1;
                mem_addr = vaddr_q;
                state_d = CMM_ST_VHI;
            end
            CMM_ST_VHI: begin
                mem_req = 1'b1;
                mem_addr = vaddr_q | 16'h0001;
                state_d = held_ok_q ? CMM_ST_PUSH : CMM_ST_RUN;
            end
            CMM_ST_PUSH: begin
                mem_req = 1'b1;
                mem_we = 1'b1;
                mem_wdata = psw_save_q;
                mem_addr = sp_q - 16'h0001;
                state_d = CMM_ST_RUN;
            end
            CMM_ST_POP: begin
                mem_req = 1'b1;
                mem_addr = sp_q;
                state_d = CMM_ST_RUN;
            end
            default: state_d = CMM_ST_RUN;
        endcase
    end
    assign sfr_select = mem_req && in_sfr;
    assign gpr_select = mem_req && in_gpr;

    logic vlo_now, vhi_now, pop_now;
    assign vlo_now = state_q == CMM_ST_VLO;
    assign vhi_now = state_q == CMM_ST_VHI;
    assign pop_now = state_q == CMM_ST_POP;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= CMM_ST_VLO;
            vaddr_q <= VEC_BASE;
            held_ok_q <= 1'b0;
            vlo_q <= 8'h00;
            psw_save_q <= PSW_RESET;
        end else begin
            state_q <= state_d;
            if (state_q == CMM_ST_RUN) begin
                psw_save_q <= psw_q;
                vaddr_q <= take_irq ? irq_vec : (op == CMM_OP_BRK) ? VEC_BREAK : tcall_addr;
                held_ok_q <= take_irq || op == CMM_OP_BRK;
            end
            if (vlo_now) begin
                vlo_q <= mem_rdata;
            end
        end
    end

    // program counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_q <= VEC_BASE;
        end else if (vhi_now) begin
            pc_q <= {mem_rdata, vlo_q};
        end else if (run) begin
            unique case (op)
                CMM_OP_ADV, CMM_OP_ALU, CMM_OP_PUSH, CMM_OP_POP, CMM_OP_EI, CMM_OP_DI,
                CMM_OP_SELRB: pc_q <= pc_q + {13'h0000, op_len};
                CMM_OP_BRANCH: pc_q <= op_target;
                CMM_OP_SCALL: pc_q <= scall_ok ? op_target : pc_q;
                default: pc_q <= pc_q;
            endcase
        end
    end

    // status word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psw_q <= PSW_RESET;
        end else if (take_irq) begin
            psw_q[PSW_IE] <= 1'b0;
        end else if (pop_now) begin
            psw_q <= mem_rdata & PSW_WMASK;
        end else if (sw_hold_q && held_ok_q == 1'b0 && w_done_q && aw_done_q &&
                     awaddr_q == REG_PSW && !bvalid_q) begin
            psw_q <= wdata_q[7:0] & PSW_WMASK;
        end else if (run) begin
            unique case (op)
                CMM_OP_EI: psw_q[PSW_IE] <= 1'b1;
                CMM_OP_DI: psw_q[PSW_IE] <= 1'b0;
                CMM_OP_SELRB: begin
                    psw_q[PSW_BANK_SELECT_HIGH] <= op_bank[1];
                    psw_q[PSW_BANK_SELECT_LOW] <= op_bank[0];
                end
                CMM_OP_ALU: begin
                    psw_q[PSW_Z] <= alu_result == 8'h00;
                    psw_q[PSW_AC] <= alu_half_carry;
                    psw_q[PSW_CY] <= alu_carry;
                end
                default: psw_q <= psw_q;
            endcase
        end
    end

    // stack pointer, undefined at reset in the part; held at zero here
    logic sp_wr;
    assign sp_wr = aw_done_q && w_done_q && !bvalid_q && awaddr_q == REG_SP;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_q <= 16'h0000;
        end else if (sp_wr) begin
            sp_q <= wdata_q[15:0];
        end else if (state_q == CMM_ST_PUSH) begin
            sp_q <= sp_q - 16'h0001;
        end else if (pop_now || (run && op == CMM_OP_POP)) begin
            sp_q <= sp_q + 16'h0001;
        end else if (run && op == CMM_OP_PUSH) begin
            sp_q <= sp_q - 16'h0001;
        end
    end

    // faults are levels while the offending state lasts, fetch_fault only while busy is low
    assign fetch_fault = !busy && !in_rom && (!pc_in_ram || pc_q >= GPR_BASE);
    assign stack_fault = !sp_in_ram;
    assign program_counter = pc_q;
    assign program_status_word = psw_q;
    assign stack_pointer = sp_q;

    // axi4-lite slave; control reg bit0 holds the sequencer for debug writes
    assign s_axi_awready = !aw_done_q && !bvalid_q;
    assign s_axi_wready = !w_done_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    logic wr_go, wr_known;
    assign wr_go = aw_done_q && w_done_q && !bvalid_q;
    assign wr_known = awaddr_q == REG_PSW || awaddr_q == REG_SP || awaddr_q == REG_CTRL;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_done_q <= 1'b0;
            w_done_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            bvalid_q <= 1'b0;
            bok_q <= 1'b0;
            sw_hold_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done_q <= 1'b1;
                awaddr_q <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bok_q <= wr_known;
                aw_done_q <= 1'b0;
                w_done_q <= 1'b0;
                if (awaddr_q == REG_CTRL) begin
                    sw_hold_q <= wdata_q[0];
                end
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bok_q ? RESP_OKAY : RESP_SLVERR;

    logic [31:0] rd_mux;
    logic rd_known;
    assign rd_known = s_axi_araddr[7:0] <= REG_VAR;
    assign rd_mux = (s_axi_araddr[7:0] == REG_PC) ? {16'h0000, pc_q} :
                    (s_axi_araddr[7:0] == REG_PSW) ? {24'h00_0000, psw_q} :
                    (s_axi_araddr[7:0] == REG_SP) ? {16'h0000, sp_q} :
                    (s_axi_araddr[7:0] == REG_CTRL) ? {31'h0000_0000, sw_hold_q} :
                    (s_axi_araddr[7:0] == REG_STAT) ?
                        {26'h000_0000, busy, stack_fault, fetch_fault, state_q} :
                    (s_axi_araddr[7:0] == REG_VAR) ? {29'h0000_0000, RAM_LARGE, ROM_SIZE} :
                    32'h0000_0000;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rok_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rok_q <= rd_known && s_axi_araddr[1:0] == 2'b00;
            rdata_q <= rd_mux;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rok_q ? RESP_OKAY : RESP_SLVERR;
    assign s_axi_rdata = rdata_q;

    sequence s_vec_fetch;
        vlo_now ##1 vhi_now;
    endsequence
    a_reset_psw_value: assert property (@(posedge aclk) $rose(aresetn) |-> psw_q == PSW_RESET)
        else $error("status word not 02H after reset");
    a_vector_pc_load: assert property (@(posedge aclk) disable iff (!aresetn)
        s_vec_fetch |=> pc_q == {$past(mem_rdata), $past(vlo_q)})
        else $error("pc not loaded from vector");
    a_vector_odd_addr: assert property (@(posedge aclk) disable iff (!aresetn)
        vhi_now |-> mem_addr[0] && mem_addr[15:1] == vaddr_q[15:1])
        else $error("vector high byte not at odd address");
    a_irq_gate_ie: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_accept |-> psw_q[PSW_IE])
        else $error("interrupt taken with enable clear");
    a_irq_low_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_accept && irq_low_priority |-> psw_q[PSW_ISP])
        else $error("low priority taken with isp clear");
    a_ack_clears_ie: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_accept |=> !psw_q[PSW_IE] ##1 vhi_now)
        else $error("acknowledge did not clear enable");
    a_irq_push_psw: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_accept |-> ##3 (mem_we && mem_wdata == $past(psw_q, 3) && mem_addr == sp_q - 16'h0001))
        else $error("status not pushed after interrupt vector");
    a_sp_predec: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == CMM_ST_PUSH && !sp_wr |=> sp_q == $past(sp_q) - 16'h0001)
        else $error("sp not decremented on push");
    a_zero_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == CMM_OP_ALU && !take_irq |=> psw_q[PSW_Z] == ($past(alu_result) == 8'h00))
        else $error("zero flag wrong");
    a_pc_advance: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == CMM_OP_ADV |=> pc_q == $past(pc_q) + {13'h0000, $past(op_len)})
        else $error("pc did not advance by length");
endmodule

// ==== dv/cmm_mem_model.sv ====
/* cmm_mem_model: byte memory on the far side of the control block, with
   vector and call tables preset. Assumes reads answer in the mem_req cycle. */
`timescale 1ns/1ns
module cmm_mem_model (
    input wire logic aclk,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] store [0:65535];
    logic [7:0] last_q = 8'h00;
    // tables: low byte even, high byte odd
    initial begin
        for (int a = 0; a < 128; a += 2) begin
            store[a] = a[7:0];
            store[a + 1] = 8'h12;
        end
    end
    // idle bus shows the inverse so a stale byte cannot pass as an answer
    assign mem_rdata = mem_req ? store[mem_addr] : ~last_q;
    always @(posedge aclk) begin
        if (mem_req && mem_we) store[mem_addr] <= mem_wdata;
        if (mem_req && !mem_we) last_q <= store[mem_addr];
    end
endmodule

// ==== dv/cmm_ctrl_tb.sv ====
/* cmm_ctrl_tb: self-checking bench for the control block, driving the
   register bus and the op port. Assumes the byte memory model as partner. */
`timescale 1ns/1ns
module cmm_ctrl_tb
    import cmm_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, op_bank;
    logic op_valid, alu_half_carry, alu_carry, irq_pending, irq_low_priority;
    logic irq_accept, busy, mem_req, mem_we, fetch_fault, stack_fault;
    logic sfr_select, gpr_select;
    logic gpr_seen = 1'b0;
    logic sfr_seen = 1'b0;
    cmm_op_type op_code;
    logic [2:0] op_len;
    logic [15:0] op_target, mem_addr, program_counter, stack_pointer;
    logic [4:0] op_index, irq_index;
    logic [7:0] alu_result, mem_wdata, mem_rdata, program_status_word;
    int fail_count = 0;
    int tests_run = 0;

    cmm_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid, .op_code,
        .op_len, .op_target, .op_index, .op_bank, .alu_result, .alu_half_carry,
        .alu_carry, .irq_pending, .irq_low_priority, .irq_index, .irq_accept, .busy,
        .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .fetch_fault,
        .stack_fault, .sfr_select, .gpr_select, .program_counter,
        .program_status_word, .stack_pointer);
    cmm_mem_model mem_model (.aclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata);

    always #25 aclk = ~aclk;

    // selects are one-cycle pulses; remember that one was seen
    always @(negedge aclk) begin
        if (gpr_select === 1'b1) gpr_seen <= 1'b1;
        if (sfr_select === 1'b1) sfr_seen <= 1'b1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test;
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ready is sampled mid-cycle, where it is settled until the next edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_go, w_go, b_go;
        s_axi_awaddr <= {24'h00_0000, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        b_go = 1'b0;
        while (!b_go) begin
            @(negedge aclk);
            aw_go = s_axi_awvalid && s_axi_awready;
            w_go = s_axi_wvalid && s_axi_wready;
            b_go = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_go) s_axi_awvalid <= 1'b0;
            if (w_go) s_axi_wvalid <= 1'b0;
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_go, r_go;
        s_axi_araddr <= {24'h00_0000, a};
        s_axi_arvalid <= 1'b1;
        r_go = 1'b0;
        while (!r_go) begin
            @(negedge aclk);
            ar_go = s_axi_arvalid && s_axi_arready;
            r_go = s_axi_rvalid === 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_go) s_axi_arvalid <= 1'b0;
        end
    endtask

    task automatic wait_idle;
        do @(negedge aclk); while (busy !== 1'b0);
        @(posedge aclk);
    endtask

    task automatic run_op(input cmm_op_type c, input logic [15:0] t);
        op_code <= c;
        op_target <= t;
        op_valid <= 1'b1;
        wait_idle();
        op_valid <= 1'b0;
        wait_idle();
    endtask

    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        repeat (3) @(posedge aclk);
        wait_idle();
        check("pc", program_counter, 16'h1200);
        check("psw", program_status_word, PSW_RESET);
        axi_read(REG_VAR, d, r);
        check("variant", d, 32'h0000_0006);
        axi_read(8'h18, d, r);
        check("rresp", r, RESP_SLVERR);
        axi_write(8'h40, 32'h0000_0000, r);
        check("bresp", r, RESP_SLVERR);
    endtask

    task automatic t_pc;
        logic [15:0] pc0;
        pc0 = program_counter;
        op_len <= 3'h3;
        run_op(CMM_OP_ADV, 16'h0000);
        check("pc adv", program_counter, pc0 + 16'h0003);
        op_len <= 3'h1;
        run_op(CMM_OP_BRANCH, 16'h0123);
        check("pc branch", program_counter, 16'h0123);
        op_index <= 5'h03;
        run_op(CMM_OP_TCALL, 16'h0000);
        check("pc tcall", program_counter, 16'h1246);
        run_op(CMM_OP_SCALL, 16'h0900);
        check("pc scall", program_counter, 16'h0900);
    endtask

    task automatic t_map;
        logic [15:0] tgt [4] = '{16'h8000, 16'hFEE0, 16'hFB00, 16'h7FFF};
        logic bad [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            run_op(CMM_OP_BRANCH, tgt[i]);
            check("fetch fault", fetch_fault, bad[i]);
        end
        run_op(CMM_OP_BRANCH, 16'h0100);
        axi_write(REG_SP, 32'h0000_FA00, r);
        check("stack fault", stack_fault, 1'b1);
        axi_write(REG_SP, 32'h0000_FEF0, r);
        check("stack fault", stack_fault, 1'b0);
        axi_read(REG_SP, d, r);
        check("sp", d, 32'h0000_FEF0);
    endtask

    task automatic t_flags;
        logic [7:0] res [3] = '{8'h00, 8'h80, 8'h01};
        logic hc [3] = '{1'b0, 1'b1, 1'b0};
        logic cy [3] = '{1'b0, 1'b1, 1'b1};
        run_op(CMM_OP_EI, 16'h0000);
        check("ie", program_status_word[PSW_IE], 1'b1);
        run_op(CMM_OP_DI, 16'h0000);
        check("ie", program_status_word[PSW_IE], 1'b0);
        for (int b = 0; b < 4; b++) begin
            op_bank <= b[1:0];
            run_op(CMM_OP_SELRB, 16'h0000);
            check("bank", {program_status_word[5], program_status_word[3]}, b[1:0]);
        end
        for (int i = 0; i < 3; i++) begin
            alu_result <= res[i];
            alu_half_carry <= hc[i];
            alu_carry <= cy[i];
            run_op(CMM_OP_ALU, 16'h0000);
            check("z", program_status_word[PSW_Z], res[i] == 8'h00);
            check("ac", program_status_word[PSW_AC], hc[i]);
            check("cy", program_status_word[PSW_CY], cy[i]);
        end
    endtask

    task automatic t_irq;
        logic [31:0] d;
        logic [1:0] r;
        // sp loaded before any stack use
        axi_write(REG_SP, 32'h0000_FE00, r);
        axi_write(REG_CTRL, 32'h0000_0001, r);
        axi_write(REG_PSW, 32'h0000_00FF, r);
        axi_read(REG_PSW, d, r);
        check("psw fixed bit", d, 32'h0000_00FB);
        axi_write(REG_PSW, 32'h0000_0080, r);
        axi_write(REG_CTRL, 32'h0000_0000, r);
        irq_low_priority <= 1'b1;
        irq_index <= 5'h0B;
        irq_pending <= 1'b1;
        repeat (4) begin
            @(negedge aclk);
            check("irq low", irq_accept, 1'b0);
        end
        @(posedge aclk);
        irq_low_priority <= 1'b0;
        do @(negedge aclk); while (irq_accept !== 1'b1);
        @(posedge aclk);
        irq_pending <= 1'b0;
        wait_idle();
        check("pc irq", program_counter, 16'h121A);
        check("ie", program_status_word[PSW_IE], 1'b0);
        check("sp", stack_pointer, 16'hFDFF);
        check("pushed", mem_model.store[16'hFDFF], 8'h80);
        run_op(CMM_OP_POPPSW, 16'h0000);
        check("psw pop", program_status_word, 8'h80);
        check("sp", stack_pointer, 16'hFE00);
        run_op(CMM_OP_DI, 16'h0000);
        irq_pending <= 1'b1;
        repeat (4) begin
            @(negedge aclk);
            check("irq off", irq_accept, 1'b0);
        end
        @(posedge aclk);
        irq_pending <= 1'b0;
        run_op(CMM_OP_BRK, 16'h0000);
        check("pc brk", program_counter, 16'h123E);
        check("sp", stack_pointer, 16'hFDFF);
        check("pushed", mem_model.store[16'hFDFF], 8'h00);
    endtask

    task automatic t_stack;
        logic [1:0] r;
        run_op(CMM_OP_RETURN_FROM_INTERRUPT, 16'h0000);
        check("sp return_from_interrupt", stack_pointer, 16'hFE00);
        run_op(CMM_OP_EI, 16'h0000);
        run_op(CMM_OP_PUSHPSW, 16'h0000);
        check("sp pushpsw", stack_pointer, 16'hFDFF);
        check("pushed", mem_model.store[16'hFDFF], 8'h80);
        run_op(CMM_OP_DI, 16'h0000);
        run_op(CMM_OP_RETURN_FROM_INTERRUPT, 16'h0000);
        check("psw return_from_interrupt", program_status_word, 8'h80);
        run_op(CMM_OP_PUSH, 16'h0000);
        check("sp push", stack_pointer, 16'hFDFF);
        run_op(CMM_OP_POP, 16'h0000);
        check("sp pop", stack_pointer, 16'hFE00);
        check("gpr select", gpr_seen, 1'b0);
        axi_write(REG_SP, 32'h0000_FEF0, r);
        run_op(CMM_OP_PUSHPSW, 16'h0000);
        check("gpr select", gpr_seen, 1'b1);
        check("sfr select", sfr_seen, 1'b0);
        axi_write(REG_SP, 32'h0000_0000, r);
        run_op(CMM_OP_PUSHPSW, 16'h0000);
        check("sfr select", sfr_seen, 1'b1);
    endtask

    initial begin
        s_axi_awaddr = '0;
        s_axi_wdata = '0;
        s_axi_araddr = '0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        op_valid = 1'b0;
        op_code = CMM_OP_NONE;
        op_len = 3'h1;
        op_target = '0;
        op_index = '0;
        op_bank = '0;
        alu_result = '0;
        alu_half_carry = 1'b0;
        alu_carry = 1'b0;
        irq_pending = 1'b0;
        irq_low_priority = 1'b0;
        irq_index = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_pc();
        t_map();
        t_flags();
        t_irq();
        t_stack();
        finish_test();
    end

    initial begin
        repeat (5000) @(posedge aclk);
        fail_count++;
        finish_test();
    end
endmodule
